// ---- rtl/cscf_top.sv ----
// Card status-change flags, enables and interrupt with a Wishbone slave
`timescale 1ns/100ps
module cscf_top
  import cscf_pkg::*;
#(
  parameter int ADR_W = CSCF_ADR_W
)
(
  // Clock and global reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus reset from the host side
  input wire logic bus_reset_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [CSCF_DAT_W-1:0] wb_dat_i,
  output logic [CSCF_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Card socket lines
  input wire logic card_detect_line_one_i,
  input wire logic card_detect_line_two_i,
  input wire logic card_ready_i,
  input wire logic battery_warning_i,
  input wire logic battery_dead_i,
  input wire logic card_status_change_signal_i,
  input wire logic ring_indicate_pin_i,
  // Interrupt and routing
  output logic irq_o,
  output logic [CSCF_CFG_SEL_W-1:0] event_irq_line_select_o
);

  // ==========================================================
  // Address decode

  function automatic logic adr_hit(input logic [ADR_W-1:0] adr, input logic [11:0] idx);
    adr_hit = (adr[ADR_W-1:2] == (ADR_W-2)'(idx));
  endfunction

  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction

  logic ack_q;
  logic ack_d;
  logic [CSCF_DAT_W-1:0] dat_q;
  logic [CSCF_DAT_W-1:0] dat_d;
  wire req = wb_cyc_i & wb_stb_i;
  // Access completes at the edge where the master sees ack
  wire acc = req & ack_q;
  wire wr = acc & wb_we_i & wb_sel_i[0];
  wire hit_flg = adr_hit(wb_adr_i, CSCF_IDX_FLAGS);
  wire hit_cfg = adr_hit(wb_adr_i, CSCF_IDX_CFG);
  wire hit_ctl = adr_hit(wb_adr_i, CSCF_IDX_CTRL);
  wire hit_sts = adr_hit(wb_adr_i, CSCF_IDX_IRQ_STS);
  wire hit_msk = adr_hit(wb_adr_i, CSCF_IDX_IRQ_MASK);
  wire rd_flg = acc & ~wb_we_i & hit_flg;

  assign ack_d = req & ~ack_q;

  // ==========================================================
  // Registers

  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [3:0] irq_sts_q;
  logic [3:0] irq_sts_d;
  logic [3:0] irq_mask_q;
  logic [3:0] irq_mask_d;
  logic [3:0] flag_q;

  wire pme_en = ctrl_q[CSCF_CTRL_PME_EN];
  wire clr_mode = ctrl_q[CSCF_CTRL_CLR_MODE];
  wire card_io = ctrl_q[CSCF_CTRL_CARD_IO];
  wire ring_en = ctrl_q[CSCF_CTRL_RING_EN];
  // bus reset gated by power management
  wire soft_rst = bus_reset_i & ~pme_en;
  wire flag_rst = rst_i | soft_rst;

  // ==========================================================
  // Input history and event detect

  logic cd1_q;
  logic cd2_q;
  logic rdy_q;
  logic bw_q;
  logic bd_q;
  logic sc_q;
  logic ri_q;
  logic hist_vld_q;
  logic [3:0] ev;
  logic [3:0] set;
  logic [3:0] clr;
  logic ev_b0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cd1_q <= 1'b0;
      cd2_q <= 1'b0;
      rdy_q <= 1'b0;
      bw_q <= 1'b0;
      bd_q <= 1'b0;
      sc_q <= 1'b0;
      ri_q <= 1'b0;
      hist_vld_q <= 1'b0;
    end
    else
    begin
      cd1_q <= card_detect_line_one_i;
      cd2_q <= card_detect_line_two_i;
      rdy_q <= card_ready_i;
      bw_q <= battery_warning_i;
      bd_q <= battery_dead_i;
      sc_q <= card_status_change_signal_i;
      ri_q <= ring_indicate_pin_i;
      hist_vld_q <= 1'b1;
    end
  end

  // Bit 0 source depends on mode: ring first, then card type
  // bit zero source
  assign ev_b0 = ring_en ? rise(ring_indicate_pin_i, ri_q) :
                 card_io ? rise(card_status_change_signal_i, sc_q) : rise(battery_dead_i, bd_q);

  // History is invalid for one cycle after reset so no false change fires
  // card detect change
  assign ev[CSCF_BIT_CD] = hist_vld_q & ((card_detect_line_one_i ^ cd1_q) | (card_detect_line_two_i ^ cd2_q));
  assign ev[CSCF_BIT_RDY] = hist_vld_q & ~card_io & rise(card_ready_i, rdy_q);
  assign ev[CSCF_BIT_BWARN] = hist_vld_q & ~card_io & rise(battery_warning_i, bw_q);
  assign ev[CSCF_BIT_BDEAD] = hist_vld_q & ev_b0;

  assign set = ev & cfg_q[3:0];

  // Read-clear only drops what software actually saw
  // clear method select
  assign clr = clr_mode ? ((wr & hit_flg) ? wb_dat_i[3:0] : 4'h0) : (rd_flg ? dat_q[3:0] : 4'h0);

  genvar g;
  generate
    for (g = 0; g < CSCF_FLAG_N; g++)
    begin : g_flag
      cscf_flag_cell u_cell (
        .clk_i(clk_i),
        .rst_i(flag_rst),
        .set_i(set[g]),
        .clr_i(clr[g]),
        .flag_o(flag_q[g])
      );
    end
  endgenerate

  // ==========================================================
  // Read view of the flags

  logic [3:0] view_raw;
  logic [7:0] flag_view;

  // In ring mode bit 0 shows the pin level rather than a latched event
  assign view_raw = {flag_q[3], flag_q[2] & ~card_io, flag_q[1] & ~card_io, ring_en ? ri_q : flag_q[0]};
  assign flag_view = {4'h0, view_raw & cfg_q[3:0]};

  // ==========================================================
  // Register writes

  always_comb
  begin
    cfg_d = cfg_q;
    ctrl_d = ctrl_q;
    irq_mask_d = irq_mask_q;
    if (wr & hit_cfg)
      cfg_d = wb_dat_i[7:0];
    if (soft_rst)
      cfg_d[3:0] = CSCF_RST_CFG[3:0];
    if (wr & hit_ctl)
      ctrl_d = wb_dat_i[7:0];
    if (wr & hit_msk)
      irq_mask_d = wb_dat_i[3:0];
  end

  assign irq_sts_d = set | (irq_sts_q & ~((wr & hit_sts) ? wb_dat_i[3:0] : 4'h0));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_q <= CSCF_RST_CFG;
      ctrl_q <= CSCF_RST_CTRL;
      irq_sts_q <= CSCF_RST_IRQ;
      irq_mask_q <= CSCF_RST_IRQ;
    end
    else
    begin
      cfg_q <= cfg_d;
      ctrl_q <= ctrl_d;
      irq_sts_q <= irq_sts_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // ==========================================================
  // Read data and ack

  always_comb
  begin
    dat_d = '0;
    if (hit_flg)
      dat_d[7:0] = flag_view;
    else if (hit_cfg)
      dat_d[7:0] = cfg_q;
    else if (hit_ctl)
      dat_d[7:0] = ctrl_q;
    else if (hit_sts)
      dat_d[3:0] = irq_sts_q;
    else if (hit_msk)
      dat_d[3:0] = irq_mask_q;
  end

  // Unmapped addresses still ack, with zero data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end
    else
    begin
      ack_q <= ack_d;
      if (ack_d & ~wb_we_i)
        dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ==========================================================
  // Interrupt and routing

  assign irq_o = |(irq_sts_q & irq_mask_q);
  assign event_irq_line_select_o = cfg_q[CSCF_CFG_SEL_LSB +: CSCF_CFG_SEL_W];

  // ==========================================================
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_RESERVED_ZERO: assert property (ack_q && $past(hit_flg && !wb_we_i) |-> wb_dat_o[7:4] == 4'h0)
    else $error("reserved flag bits read nonzero");
  AST_DISABLED_ZERO: assert property (ack_q && $past(hit_flg && !wb_we_i) |-> (wb_dat_o[3:0] & ~$past(cfg_q[3:0])) == 4'h0)
    else $error("disabled source flag read as one");
  AST_CD_SET: assert property (ev[CSCF_BIT_CD] && cfg_q[CSCF_BIT_CD] && !bus_reset_i |=> flag_q[CSCF_BIT_CD] [*1])
    else $error("card detect change not flagged");
  AST_READY_SET: assert property (hist_vld_q && !card_io && cfg_q[2] && card_ready_i && !rdy_q && !bus_reset_i
                                  |=> flag_q[CSCF_BIT_RDY])
    else $error("ready rise not flagged");
  AST_IO_ZERO: assert property (ack_q && $past(hit_flg && !wb_we_i && card_io) |-> wb_dat_o[2:1] == 2'b00)
    else $error("memory-only flags nonzero with I/O card");
  AST_BIT0_SET: assert property (set[CSCF_BIT_BDEAD] && !bus_reset_i |=> flag_q[CSCF_BIT_BDEAD])
    else $error("bit zero event not flagged");
  AST_BUS_RST: assert property (bus_reset_i && !pme_en |=> flag_q == 4'h0 && cfg_q[3:0] == 4'h0)
    else $error("bus reset did not clear flags");
  AST_PME_KEEP: assert property (bus_reset_i && pme_en && clr == 4'h0 |=> (flag_q & $past(flag_q)) == $past(flag_q))
    else $error("bus reset cleared flags with power management on");
  AST_W1C: assert property (wr && hit_flg && clr_mode && wb_dat_i[3] && !set[3] |=> !flag_q[3])
    else $error("write one did not clear flag");
  AST_RD_CLR: assert property (rd_flg && !clr_mode && dat_q[3] && !set[3] && !bus_reset_i |=> !flag_q[3])
    else $error("read did not clear flag");
  AST_SET_WINS: assert property (set[0] && clr[0] && !bus_reset_i |=> flag_q[0])
    else $error("event lost against clear");
  AST_IRQ: assert property (set[3] && irq_mask_q[3] && !(wr && hit_msk)
                            |=> irq_o ##1 (irq_o || $past(wr && (hit_sts || hit_msk))))
    else $error("enabled event raised no interrupt");
  AST_ACK_PULSE: assert property (ack_q |=> !ack_q)
    else $error("ack held beyond one cycle");

  // Gating, routing and bus-side checks
  AST_ENABLED_ONLY: assert property ((flag_q & ~$past(flag_q) & ~$past(cfg_q[3:0])) == 4'h0)
    else $error("flag rose for a disabled source");
  AST_RST_QUIET: assert property ($past(rst_i) |-> ev == 4'h0)
    else $error("false event right after reset");
  AST_RING_VIEW: assert property (ack_q && $past(hit_flg && !wb_we_i && ring_en && cfg_q[CSCF_BIT_BDEAD])
                                  |-> wb_dat_o[0] == $past(ri_q))
    else $error("ring mode bit zero does not follow the pin");
  AST_CFG_WR: assert property (wr && hit_cfg && !soft_rst |=> cfg_q == $past(wb_dat_i[7:0]))
    else $error("config write did not land");
  AST_ACK_REQ: assert property (ack_q |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  AST_SEL_ROUTE: assert property (wr && hit_cfg |=> event_irq_line_select_o == $past(wb_dat_i[7:4]))
    else $error("line select does not follow config write");
  AST_SEL_KEEP: assert property (bus_reset_i && !(wr && hit_cfg)
                                 |=> $stable(event_irq_line_select_o))
    else $error("bus reset disturbed line select");
  AST_STS_W1C: assert property (wr && hit_sts && wb_dat_i[3] && !set[3] |=> !irq_sts_q[3])
    else $error("status write one did not clear");
  AST_MSK_WR: assert property (wr && hit_msk |=> irq_mask_q == $past(wb_dat_i[3:0]))
    else $error("mask write did not land");

  COV_READ_CLEAR: cover property (rd_flg && dat_q[3] && !clr_mode);
  COV_W1C: cover property (wr && hit_flg && clr_mode && flag_q != 4'h0);
  COV_SET_CLR: cover property (set != 4'h0 && clr != 4'h0);
  COV_IRQ: cover property (!irq_o ##1 irq_o);
  COV_RING: cover property (ring_en && set[CSCF_BIT_BDEAD]);

endmodule

// ---- rtl/cscf_pkg.sv ----
// Shared constants for the card status-change flag block
package cscf_pkg;

  // ==========================================================
  // Bus geometry
  localparam int CSCF_ADR_W = 16;
  localparam int CSCF_DAT_W = 32;
  localparam int CSCF_FLAG_N = 4;

  // ==========================================================
  // Register indexes, byte address is four times the index
  localparam logic [11:0] CSCF_IDX_FLAGS = 12'h804;
  localparam logic [11:0] CSCF_IDX_CFG = 12'h805;
  localparam logic [11:0] CSCF_IDX_CTRL = 12'h810;
  localparam logic [11:0] CSCF_IDX_IRQ_STS = 12'h811;
  localparam logic [11:0] CSCF_IDX_IRQ_MASK = 12'h812;

  // ==========================================================
  // Flag and enable bit positions (same layout in both registers)
  localparam int CSCF_BIT_CD = 3;
  localparam int CSCF_BIT_RDY = 2;
  localparam int CSCF_BIT_BWARN = 1;
  localparam int CSCF_BIT_BDEAD = 0;
  localparam int CSCF_CFG_SEL_LSB = 4;
  localparam int CSCF_CFG_SEL_W = 4;

  // ==========================================================
  // Control register bit positions
  localparam int CSCF_CTRL_PME_EN = 0;
  localparam int CSCF_CTRL_CLR_MODE = 2;
  localparam int CSCF_CTRL_CARD_IO = 5;
  localparam int CSCF_CTRL_RING_EN = 7;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CSCF_RST_FLAGS = 8'h00;
  localparam logic [7:0] CSCF_RST_CFG = 8'h00;
  localparam logic [7:0] CSCF_RST_CTRL = 8'h00;
  localparam logic [3:0] CSCF_RST_IRQ = 4'h0;

endpackage

// ---- rtl/cscf_flag_cell.sv ----
// Sticky event flag with set-over-clear priority
`timescale 1ns/100ps
module cscf_flag_cell
  import cscf_pkg::*;
(
  // Clock and flag reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Event and clear
  input wire logic set_i,
  input wire logic clr_i,
  // Flag
  output logic flag_o
);

  logic flag_q;
  logic flag_d;

  assign flag_d = set_i | (flag_q & ~clr_i);
  assign flag_o = flag_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_q <= CSCF_RST_FLAGS[0];
    else
      flag_q <= flag_d;
  end

endmodule

// ---- tb/cscf_card_model.sv ----
// Behavioural card in the socket driving its status lines
`timescale 1ns/100ps
module cscf_card_model
(
  // Clock
  input wire logic clk_i,
  // Ring, status change, dead, warning, ready, detect two, detect one
  output logic [6:0] lines_o
);
  initial lines_o = 7'h00;
  // Lines move on an edge, as a card synchronised to the socket would
  task automatic drive(input logic [6:0] v);
    @(posedge clk_i);
    lines_o <= v;
  endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the card status-change flag block
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  import cscf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic bus_reset = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [15:0] wb_adr = 16'h0000;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic [3:0] sel_o;
  logic [6:0] lines;
  int num_errors = 0;
  int n_tests = 0;
  localparam logic [15:0] A_FLG = 16'h2010;
  localparam logic [15:0] A_CFG = 16'h2014;
  localparam logic [15:0] A_CTL = 16'h2040;
  localparam logic [15:0] A_STS = 16'h2044;
  localparam logic [15:0] A_MSK = 16'h2048;

  always #20 clk_i = ~clk_i;

  cscf_card_model card (.clk_i(clk_i), .lines_o(lines));

  cscf_top uut (.clk_i(clk_i), .rst_i(rst_i), .bus_reset_i(bus_reset), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .card_detect_line_one_i(lines[0]),
    .card_detect_line_two_i(lines[1]), .card_ready_i(lines[2]), .battery_warning_i(lines[3]),
    .battery_dead_i(lines[4]), .card_status_change_signal_i(lines[5]),
    .ring_indicate_pin_i(lines[6]), .irq_o(irq_o), .event_irq_line_select_o(sel_o));

  // ==========================================================
  // Bus and helper tasks
  task automatic wb(input logic we, input logic [15:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= {24'h000000, d};
    n = 0;
    @(posedge clk_i);
    // Bounded wait so a missing ack cannot hang the bus
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20)
      num_errors++;
    r = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    logic [31:0] r;
    wb(1'b0, a, 8'h00, r);
    `CHK(r, {24'h000000, e})
  endtask

  task automatic ev(input logic [6:0] v);
    card.drive(v);
    repeat (3) @(posedge clk_i);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_map();
    rd(A_FLG, 8'h00);
    rd(A_CFG, 8'h00);
    rd(A_CTL, 8'h00);
    rd(16'h2100, 8'h00);
    wr(A_CFG, 8'h50);
    rd(A_CFG, 8'h50);
    `CHK(sel_o, 4'h5)
  endtask

  task automatic t_enable_irq();
    ev(7'h01);
    rd(A_FLG, 8'h00);
    `CHK(irq_o, 1'b0)
    wr(A_CFG, 8'h0f);
    ev(7'h03);
    `CHK(irq_o, 1'b0)
    wr(A_MSK, 8'h0f);
    @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    rd(A_FLG, 8'h08);
    rd(A_FLG, 8'h00);
    `CHK(irq_o, 1'b1)
    rd(A_STS, 8'h08);
    rd(A_MSK, 8'h0f);
    wr(A_STS, 8'h08);
    @(posedge clk_i);
    `CHK(irq_o, 1'b0)
  endtask

  task automatic t_memory_w1c();
    wr(A_CTL, 8'h04);
    ev(7'h07);
    ev(7'h0f);
    ev(7'h1f);
    rd(A_FLG, 8'h07);
    rd(A_FLG, 8'h07);
    wr(A_FLG, 8'hf3);
    rd(A_FLG, 8'h04);
    wr(A_FLG, 8'h04);
    rd(A_FLG, 8'h00);
    wr(A_STS, 8'h0f);
  endtask

  task automatic t_io_card();
    ev(7'h03);
    wr(A_CTL, 8'h20);
    ev(7'h07);
    ev(7'h0f);
    ev(7'h23);
    rd(A_FLG, 8'h01);
    rd(A_FLG, 8'h00);
    wr(A_CTL, 8'ha0);
    ev(7'h63);
    rd(A_FLG, 8'h01);
    ev(7'h23);
    rd(A_FLG, 8'h00);
  endtask

  task automatic t_bus_reset();
    wr(A_CFG, 8'ha8);
    wr(A_CTL, 8'h01);
    ev(7'h22);
    bus_reset <= 1'b1;
    @(posedge clk_i);
    bus_reset <= 1'b0;
    rd(A_CFG, 8'ha8);
    rd(A_FLG, 8'h08);
    wr(A_CTL, 8'h00);
    ev(7'h23);
    bus_reset <= 1'b1;
    @(posedge clk_i);
    bus_reset <= 1'b0;
    rd(A_FLG, 8'h00);
    rd(A_CFG, 8'ha0);
    wr(A_CFG, 8'ha8);
    rd(A_FLG, 8'h00);
    `CHK(sel_o, 4'ha)
  endtask

  task automatic t_set_wins();
    ev(7'h0f);
    ev(7'h1f);
    ev(7'h0f);
    // Battery dead rises on the very edge the write-one clear lands
    fork
      wr(A_FLG, 8'h01);
      begin
        @(posedge clk_i);
        card.drive(7'h1f);
      end
    join
    rd(A_FLG, 8'h01);
    wr(A_FLG, 8'h01);
    rd(A_FLG, 8'h00);
    wr(A_STS, 8'h0f);
  endtask

  // ==========================================================
  // Verdict and sequence
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_map();
    t_enable_irq();
    t_memory_w1c();
    t_set_wins();
    t_io_card();
    t_bus_reset();
    wrap_up();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end
endmodule
